// ===== dsl_security.sv
// security command handling of the drive controller
// assumes a plain one-cycle register port; data words at the data offset
`timescale 1ns/1ps
`default_nettype none
`include "dsl_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - erase unit f4h takes 512-byte block
// - erase on match clears user password, lock
// - erase keeps master password
// - erase aborts unless prepare came just before
// - erase aborts while frozen
// - freeze f5h enters frozen state
// - frozen aborts set, unlock, disable, erase
// - only power loss or reset leaves frozen
// - repeated freeze completes, stays frozen
// - freeze aborts while locked
// - locked aborts every media access command
// - set password f1h, bit0 picks target
// - bit8 picks level, other bits ignored
// - set password aborts if locked or frozen
// - user high arms lock, both unlock
// - user maximum arms lock, user only
// - master set stores, never arms lock
// - prepare f3h enables next erase
// - five tries, zero blocks erase, unlock
// - abort sets error register abort bit
module dsl_security
	import dsl_pkg::*;
#(
	parameter int PW_WORDS = `DSL_PW_WORDS
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_power_on,
	input wire logic [11:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	output logic o_intrq,
	output logic o_erase_req,
	output logic o_locked,
	output logic o_frozen
);
	dsl_state_t state;
	logic [7:0] cmd;
	logic [7:0] err;
	logic bsy;
	logic drq;
	logic frozen;
	logic locked;
	logic lock_armed;
	logic level_max;
	logic user_pw_valid;
	logic prepared;
	logic [2:0] tries;
	logic [8:0] word_cnt;
	logic ident;
	logic level_in;
	logic match_rst;
	logic match_user;
	logic match_master;
	logic [15:0] user_pw [PW_WORDS];
	logic [15:0] master_pw [PW_WORDS];
	logic [7:0] sector_count_reg, sector_number_reg;
	logic [7:0] cylinder_low_reg, cylinder_high_reg, drive_head_reg;
	logic cmd_wr;
	logic data_wr;
	logic pw_word;
	logic [3:0] pw_idx;
	logic abort_now;
	logic [15:0] next_rdata;

	assign cmd_wr = i_wr && (i_addr == `DSL_OFF_CMD) && state == DSL_IDLE;
	assign data_wr = i_wr && (i_addr == `DSL_OFF_DATA) && drq;
	assign pw_word = data_wr && (word_cnt >= 9'h001) &&
		(word_cnt <= 9'(PW_WORDS));
	assign pw_idx = 4'(word_cnt - 9'h001);
	assign o_locked = locked;
	assign o_frozen = frozen;

	function automatic logic is_media(input logic [7:0] c);
		case (c)
			8'hc8, 8'hca, 8'h22, 8'h32, 8'hc4, 8'h20, 8'hc5, 8'h30,
			8'h3c: is_media = 1'b1;
			default: is_media = 1'b0;
		endcase
	endfunction

	function automatic logic has_block(input logic [7:0] c);
		has_block = (c == `DSL_CMD_SET_PW) || (c == `DSL_CMD_ERASE_UNIT) ||
			(c == `DSL_CMD_UNLOCK) || (c == `DSL_CMD_DISABLE_PW);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// abort decisions taken when the command code lands
	always_comb begin
		abort_now = 1'b0;
		case (i_wdata[7:0])
			`DSL_CMD_ERASE_UNIT:
				abort_now = frozen || !prepared ||
					(tries == 3'h0);
			`DSL_CMD_UNLOCK, `DSL_CMD_DISABLE_PW:
				abort_now = frozen || (tries == 3'h0 && i_wdata[7:0] ==
					`DSL_CMD_UNLOCK);
			`DSL_CMD_SET_PW:
				abort_now = frozen || locked;
			`DSL_CMD_FREEZE:
				abort_now = locked;
			`DSL_CMD_ERASE_PREP:
				abort_now = frozen;
			default:
				abort_now = locked && is_media(i_wdata[7:0]);
		endcase
	end

	// password comparators, one per stored password
	dsl_pw_cmp #(.PW_WORDS(PW_WORDS)) u_cmp_user (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_clear(match_rst),
		.i_valid(pw_word),
		.i_word(i_wdata),
		.i_stored(user_pw[pw_idx]),
		.o_match(match_user)
	);
	dsl_pw_cmp #(.PW_WORDS(PW_WORDS)) u_cmp_master (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_clear(match_rst),
		.i_valid(pw_word),
		.i_word(i_wdata),
		.i_stored(master_pw[pw_idx]),
		.o_match(match_master)
	);
	assign match_rst = cmd_wr;

	wire exec_ok = (state == DSL_EXEC) && !err[`DSL_ABORT_BIT];
	wire pw_ok = ident ? (match_master && !(level_max &&
		(locked || cmd == `DSL_CMD_UNLOCK))) :
		(match_user && user_pw_valid);

	////////////////////////////////////////////////////////////////////////////
	// command sequencer
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= DSL_IDLE;
			cmd <= 8'h00;
			bsy <= 1'b0;
			drq <= 1'b0;
			err <= 8'h00;
			word_cnt <= 9'h000;
			ident <= 1'b0;
			level_in <= 1'b0;
			o_intrq <= 1'b0;
		end else begin
			if (i_rd && i_addr == `DSL_OFF_CMD) begin
				o_intrq <= 1'b0;
			end
			case (state)
				DSL_IDLE: begin
					if (cmd_wr) begin
						cmd <= i_wdata[7:0];
						err <= 8'h00;
						bsy <= 1'b1;
						word_cnt <= 9'h000;
						if (abort_now) begin
							err[`DSL_ABORT_BIT] <= 1'b1;
							state <= DSL_DONE;
						end else if (has_block(i_wdata[7:0])) begin
							state <= DSL_RECV;
						end else begin
							state <= DSL_EXEC;
						end
					end
				end
				DSL_RECV: begin
					bsy <= 1'b0;
					drq <= 1'b1;
					if (data_wr) begin
						if (word_cnt == 9'h000) begin
							ident <= i_wdata[`DSL_BIT_IDENT];
							level_in <= i_wdata[`DSL_BIT_LEVEL];
						end
						word_cnt <= word_cnt + 9'h001;
						if (word_cnt == `DSL_BLOCK_WORDS - 9'h001) begin
							drq <= 1'b0;
							bsy <= 1'b1;
							state <= DSL_EXEC;
						end
					end
				end
				DSL_EXEC: begin
					if (cmd != `DSL_CMD_SET_PW && has_block(cmd) &&
						!pw_ok) begin
						err[`DSL_ABORT_BIT] <= 1'b1;
					end
					state <= DSL_DONE;
				end
				DSL_DONE: begin
					bsy <= 1'b0;
					o_intrq <= 1'b1;
					state <= DSL_IDLE;
				end
				default: state <= DSL_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// security state
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			frozen <= 1'b0;
			prepared <= 1'b0;
			tries <= `DSL_UNLOCK_TRIES;
			locked <= 1'b0;
		end else begin
			if (i_power_on) begin
				frozen <= 1'b0;
				locked <= lock_armed;
			end
			if (cmd_wr) begin
				prepared <= (i_wdata[7:0] == `DSL_CMD_ERASE_PREP) &&
					!abort_now;
				if (i_wdata[7:0] == `DSL_CMD_FREEZE && !locked) begin
					frozen <= 1'b1;
				end
			end
			if (exec_ok && pw_ok && (cmd == `DSL_CMD_ERASE_UNIT ||
				cmd == `DSL_CMD_UNLOCK || cmd == `DSL_CMD_DISABLE_PW)) begin
				locked <= 1'b0;
			end
			if (exec_ok && !pw_ok && cmd == `DSL_CMD_UNLOCK && locked &&
				tries != 3'h0) begin
				tries <= tries - 3'h1;
			end
		end
	end

	// lock arming and level survive power cycles; reset only at assembly
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lock_armed <= 1'b0;
			level_max <= 1'b0;
			user_pw_valid <= 1'b0;
			o_erase_req <= 1'b0;
		end else begin
			o_erase_req <= 1'b0;
			if (exec_ok && cmd == `DSL_CMD_SET_PW && !ident) begin
				lock_armed <= 1'b1;
				level_max <= level_in;
				user_pw_valid <= 1'b1;
			end
			if (exec_ok && pw_ok && (cmd == `DSL_CMD_ERASE_UNIT ||
				cmd == `DSL_CMD_DISABLE_PW)) begin
				lock_armed <= 1'b0;
				user_pw_valid <= 1'b0;
			end
			if (exec_ok && pw_ok && cmd == `DSL_CMD_ERASE_UNIT) begin
				o_erase_req <= 1'b1;
			end
		end
	end

	// password stores; master untouched by erase, written only by set
	always_ff @(posedge i_sys_clk) begin
		if (pw_word && state == DSL_RECV && cmd == `DSL_CMD_SET_PW) begin
			if (ident) begin
				master_pw[pw_idx] <= i_wdata;
			end else begin
				user_pw[pw_idx] <= i_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// other task-file registers are plain storage
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sector_count_reg <= 8'h00;
			sector_number_reg <= 8'h00;
			cylinder_low_reg <= 8'h00;
			cylinder_high_reg <= 8'h00;
			drive_head_reg <= 8'h00;
		end else if (i_wr) begin
			case (i_addr)
				`DSL_OFF_SECTOR_COUNT: sector_count_reg <= i_wdata[7:0];
				`DSL_OFF_SECTOR_NUM: sector_number_reg <= i_wdata[7:0];
				`DSL_OFF_CYL_LOW: cylinder_low_reg <= i_wdata[7:0];
				`DSL_OFF_CYL_HIGH: cylinder_high_reg <= i_wdata[7:0];
				`DSL_OFF_DRIVE_HEAD: drive_head_reg <= i_wdata[7:0];
				default: ;
			endcase
		end
	end

	// read data one cycle after the strobe, zero otherwise
	always_comb begin
		next_rdata = 16'h0000;
		case (i_addr)
			`DSL_OFF_ERR: next_rdata = {8'h00, err};
			`DSL_OFF_SECTOR_COUNT: next_rdata = {8'h00, sector_count_reg};
			`DSL_OFF_SECTOR_NUM: next_rdata = {8'h00, sector_number_reg};
			`DSL_OFF_CYL_LOW: next_rdata = {8'h00, cylinder_low_reg};
			`DSL_OFF_CYL_HIGH: next_rdata = {8'h00, cylinder_high_reg};
			`DSL_OFF_DRIVE_HEAD: next_rdata = {8'h00, drive_head_reg};
			`DSL_OFF_CMD: next_rdata = {8'h00, bsy, !bsy, 2'h0, drq,
				2'h0, err[`DSL_ABORT_BIT]};
			`DSL_OFF_SEC: next_rdata = {10'h000, tries, level_max, locked,
				frozen};
			default: next_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	a_frozen_sticky: assert property (@(posedge i_sys_clk)
		disable iff (!i_reset_n) frozen && !i_power_on |=> frozen)
		else $error("frozen cleared");
	a_freeze_sets: assert property (@(posedge i_sys_clk)
		disable iff (!i_reset_n) cmd_wr && !locked && i_wdata[7:0] ==
		`DSL_CMD_FREEZE |=> frozen) else $error("freeze not taken");
	a_freeze_locked: assert property (@(posedge i_sys_clk)
		disable iff (!i_reset_n) cmd_wr && locked && i_wdata[7:0] ==
		`DSL_CMD_FREEZE |=> err[`DSL_ABORT_BIT])
		else $error("freeze not aborted");
	a_erase_prep: assert property (@(posedge i_sys_clk)
		disable iff (!i_reset_n) cmd_wr && !prepared && i_wdata[7:0] ==
		`DSL_CMD_ERASE_UNIT |=> err[`DSL_ABORT_BIT] && state == DSL_DONE)
		else $error("erase no prep");
	a_erase_frozen: assert property (@(posedge i_sys_clk)
		disable iff (!i_reset_n) cmd_wr && frozen && i_wdata[7:0] ==
		`DSL_CMD_ERASE_UNIT |=> err[`DSL_ABORT_BIT])
		else $error("erase while frozen");
	a_setpw_abort: assert property (@(posedge i_sys_clk)
		disable iff (!i_reset_n) cmd_wr && (locked || frozen) &&
		i_wdata[7:0] == `DSL_CMD_SET_PW |=> err[`DSL_ABORT_BIT])
		else $error("set password not aborted");
	a_media_locked: assert property (@(posedge i_sys_clk)
		disable iff (!i_reset_n) cmd_wr && locked &&
		is_media(i_wdata[7:0]) |=> err[`DSL_ABORT_BIT])
		else $error("media access while locked");
	a_busy_done: assert property (@(posedge i_sys_clk)
		disable iff (!i_reset_n) state == DSL_DONE |=> !bsy && o_intrq)
		else $error("no completion");
	a_prep_clear: assert property (@(posedge i_sys_clk)
		disable iff (!i_reset_n) cmd_wr && i_wdata[7:0] !=
		`DSL_CMD_ERASE_PREP |=> !prepared) else $error("prepare kept");
endmodule
`default_nettype wire

// ===== dsl_consts.svh
// constants for the drive security command block
// assumes the task-file offsets are the byte addresses of the plain port
`ifndef DSL_CONSTS_SVH
`define DSL_CONSTS_SVH

`define DSL_OFF_ERR 12'h1f1
`define DSL_OFF_SECTOR_COUNT 12'h1f2
`define DSL_OFF_SECTOR_NUM 12'h1f3
`define DSL_OFF_CYL_LOW 12'h1f4
`define DSL_OFF_CYL_HIGH 12'h1f5
`define DSL_OFF_DRIVE_HEAD 12'h1f6
`define DSL_OFF_CMD 12'h1f7
`define DSL_OFF_DATA 12'h1f0
`define DSL_OFF_SEC 12'h1f8

`define DSL_CMD_SET_PW 8'hf1
`define DSL_CMD_UNLOCK 8'hf2
`define DSL_CMD_ERASE_PREP 8'hf3
`define DSL_CMD_ERASE_UNIT 8'hf4
`define DSL_CMD_FREEZE 8'hf5
`define DSL_CMD_DISABLE_PW 8'hf6

`define DSL_BIT_IDENT 0
`define DSL_BIT_LEVEL 8
`define DSL_ABORT_BIT 2
`define DSL_COND_BSY 7
`define DSL_COND_DRDY 6
`define DSL_COND_DRQ 3
`define DSL_COND_ERR 0

`define DSL_UNLOCK_TRIES 3'h5
`define DSL_BLOCK_WORDS 9'h100
`define DSL_PW_WORDS 16

`endif

// ===== dsl_pkg.sv
// types for the drive security command block
// assumes dsl_consts.svh is compiled alongside
package dsl_pkg;
	typedef enum logic [2:0] {
		DSL_IDLE,
		DSL_RECV,
		DSL_EXEC,
		DSL_DONE
	} dsl_state_t;
endpackage

// ===== dsl_pw_cmp.sv
// password comparator over one 16-bit word stream
// assumes words arrive in order after a start pulse that comes before word 1
`timescale 1ns/1ps
`default_nettype none
module dsl_pw_cmp #(
	parameter int PW_WORDS = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_clear,
	input wire logic i_valid,
	input wire logic [15:0] i_word,
	input wire logic [15:0] i_stored,
	output logic o_match
);
	// match stays high until any word disagrees
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_match <= 1'b1;
		end else if (i_clear) begin
			o_match <= 1'b1;
		end else if (i_valid && (i_word != i_stored)) begin
			o_match <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== dsl_host.sv
// host-side model driving the task-file port of the security block
// assumes one clock; strobes change only right after a rising edge
`timescale 1ns/1ps
`default_nettype none
`include "dsl_consts.svh"
module dsl_host (
	input wire logic i_sys_clk,
	input wire logic [15:0] i_rdata,
	output logic [11:0] o_addr,
	output logic [15:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	initial begin
		o_addr = 12'h000;
		o_wdata = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// released lines show the inverse, so stale values never pass
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask

	task automatic rd(input logic [11:0] a, output logic [15:0] v);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_sys_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(negedge i_sys_clk);
		v = i_rdata;
	endtask

	////////////////////////////////////////////////////////////////////////
	// whole 256-word block, reserved words random
	task automatic blk(input logic [15:0] c, input logic [15:0] p [16]);
		wr(`DSL_OFF_DATA, c);
		for (int i = 0; i < 16; i++) begin
			wr(`DSL_OFF_DATA, p[i]);
		end
		for (int i = 17; i < 256; i++) begin
			wr(`DSL_OFF_DATA, 16'($urandom));
		end
	endtask
endmodule
`default_nettype wire

// ===== test_drive_security_lock_commands.sv
// self-checking bench for the drive security command block
// assumes dsl_host as the far side; power cycles via a pulse
`timescale 1ns/1ps
`default_nettype none
`include "dsl_consts.svh"
module test_drive_security_lock_commands;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic [15:0] rdata;
	logic intrq;
	logic erase_req;
	logic locked;
	logic frozen;
	logic rd_seen = 1'b0;
	logic [31:0] q;
	logic [31:0] expq [$];
	logic [15:0] v;
	logic [15:0] pw [3][16];
	logic [7:0] frz_cmds [5] = '{8'hf1, 8'hf2, 8'hf6, 8'hf3, 8'hf4};
	int n_mismatch = 0;
	int comparisons = 0;
	int n_erase = 0;

	always #20 clk = ~clk;

	dsl_host host (.i_sys_clk(clk), .i_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd));

	dsl_security uut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_power_on(pwr),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .o_intrq(intrq), .o_erase_req(erase_req),
		.o_locked(locked), .o_frozen(frozen));

	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// read data checked by the watcher below, in order of issue
	always @(posedge clk) rd_seen <= rd;
	always @(posedge clk) begin
		if (erase_req === 1'b1) begin
			n_erase++;
		end
	end
	always @(negedge clk) begin
		if (rd_seen) begin
			q = expq.pop_front();
			chk("rdata", q[15:0], rdata & q[31:16]);
		end
	end

	task automatic rdx(input logic [11:0] a, input logic [15:0] e,
		input logic [15:0] m);
		expq.push_back({m, e});
		host.rd(a, v);
	endtask

	// reserved control bits random: the device must ignore them
	function automatic logic [15:0] ctl(input logic id, input logic lvl);
		return {7'($urandom), lvl, 7'($urandom), id};
	endfunction

	task automatic st(input logic l, input logic f, input int e);
		@(negedge clk);
		chk("locked", {15'h0, l}, {15'h0, locked});
		chk("frozen", {15'h0, f}, {15'h0, frozen});
		chk("erase", 16'(e), 16'(n_erase));
	endtask

	task automatic pcyc;
		@(posedge clk);
		pwr <= 1'b1;
		@(posedge clk);
		pwr <= 1'b0;
	endtask

	task automatic wait_irq(input int n, output bit got);
		got = 1'b0;
		for (int i = 0; i < n && !got; i++) begin
			@(negedge clk);
			got = (intrq === 1'b1);
		end
	endtask

	// no interrupt soon means the device wants the data block
	task automatic go(input logic [7:0] c, input logic [15:0] w,
		input int k, input logic ab);
		bit got;
		host.wr(`DSL_OFF_CMD, {8'h00, c});
		wait_irq(8, got);
		if (!got) begin
			rdx(`DSL_OFF_CMD, 16'h0008, 16'h0008);
			host.blk(w, pw[k]);
			wait_irq(40, got);
		end
		if (!got) begin
			n_mismatch++;
			$display("[FAIL] intrq expected 1 seen 0");
			summarize();
		end
		rdx(`DSL_OFF_ERR, {13'h0, ab, 2'h0}, 16'h0004);
		rdx(`DSL_OFF_CMD, {15'h0, ab}, 16'h0081);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hea03));
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 16; j++) begin
				pw[i][j] = 16'($urandom);
			end
		end
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rdx(`DSL_OFF_SEC, 16'h0028, 16'h003b);
		go(`DSL_CMD_SET_PW, ctl(1'b1, 1'b1), 1, 1'b0);
		go(`DSL_CMD_SET_PW, ctl(1'b1, 1'b0), 1, 1'b0);
		pcyc();
		st(1'b0, 1'b0, 0);
		go(8'h20, 16'h0000, 0, 1'b0);
		go(`DSL_CMD_SET_PW, ctl(1'b0, 1'b0), 0, 1'b0);
		st(1'b0, 1'b0, 0);
		pcyc();
		st(1'b1, 1'b0, 0);
		go(8'hc8, 16'h0000, 0, 1'b1);
		go(`DSL_CMD_FREEZE, 16'h0000, 0, 1'b1);
		go(`DSL_CMD_SET_PW, ctl(1'b1, 1'b0), 1, 1'b1);
		go(`DSL_CMD_ERASE_PREP, 16'h0000, 0, 1'b0);
		go(`DSL_CMD_ERASE_UNIT, ctl(1'b0, 1'b0), 2, 1'b1);
		st(1'b1, 1'b0, 0);
		go(`DSL_CMD_ERASE_PREP, 16'h0000, 0, 1'b0);
		go(`DSL_CMD_ERASE_UNIT, ctl(1'b1, 1'b0), 1, 1'b0);
		st(1'b0, 1'b0, 1);
		pcyc();
		st(1'b0, 1'b0, 1);
		go(`DSL_CMD_ERASE_UNIT, ctl(1'b1, 1'b0), 1, 1'b1);
		go(`DSL_CMD_ERASE_PREP, 16'h0000, 0, 1'b0);
		go(`DSL_CMD_SET_PW, ctl(1'b0, 1'b1), 0, 1'b0);
		go(`DSL_CMD_ERASE_UNIT, ctl(1'b0, 1'b0), 0, 1'b1);
		pcyc();
		st(1'b1, 1'b0, 1);
		go(`DSL_CMD_ERASE_PREP, 16'h0000, 0, 1'b0);
		go(`DSL_CMD_ERASE_UNIT, ctl(1'b1, 1'b0), 1, 1'b1);
		go(`DSL_CMD_ERASE_PREP, 16'h0000, 0, 1'b0);
		go(`DSL_CMD_ERASE_UNIT, ctl(1'b0, 1'b0), 0, 1'b0);
		st(1'b0, 1'b0, 2);
		go(`DSL_CMD_ERASE_PREP, 16'h0000, 0, 1'b0);
		go(`DSL_CMD_ERASE_UNIT, ctl(1'b1, 1'b0), 1, 1'b0);
		st(1'b0, 1'b0, 3);
		// exhaust the unlock tries, then a good erase is still refused
		go(`DSL_CMD_SET_PW, ctl(1'b0, 1'b0), 0, 1'b0);
		pcyc();
		for (int i = 0; i < 5; i++) begin
			go(`DSL_CMD_UNLOCK, ctl(1'b0, 1'b0), 2, 1'b1);
		end
		rdx(`DSL_OFF_SEC, 16'h0002, 16'h003b);
		go(`DSL_CMD_ERASE_PREP, 16'h0000, 0, 1'b0);
		go(`DSL_CMD_ERASE_UNIT, ctl(1'b0, 1'b0), 0, 1'b1);
		st(1'b1, 1'b0, 3);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdx(`DSL_OFF_SEC, 16'h0028, 16'h003b);
		go(`DSL_CMD_FREEZE, 16'h0000, 0, 1'b0);
		st(1'b0, 1'b1, 3);
		go(`DSL_CMD_FREEZE, 16'h0000, 0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			go(frz_cmds[i], ctl(1'b0, 1'b0), 0, 1'b1);
		end
		st(1'b0, 1'b1, 3);
		pcyc();
		st(1'b0, 1'b0, 3);
		chk("queue", 16'h0000, 16'(expq.size()));
		summarize();
	end
endmodule
`default_nettype wire
